// *** verilog/accel_cfg_pkg.sv ***
// Constants and carrier types shared by the bytecode accelerator configuration registers.
package accel_cfg_pkg;

    // Coprocessor transfer encoding used by every configuration register.
    localparam logic [2:0] CP_OPC1 = 3'h7;
    localparam logic [3:0] CP_CRM = 4'h0;
    localparam logic [2:0] CP_OPC2 = 3'h0;

    // Primary register numbers of the configuration registers.
    localparam logic [3:0] CRN_IDENT = 4'h0;
    localparam logic [3:0] CRN_OS_CTRL = 4'h1;
    localparam logic [3:0] CRN_MAIN_CFG = 4'h2;
    localparam logic [3:0] CRN_PARAMS = 4'h3;
    localparam logic [3:0] CRN_XLATE = 4'h4;

    // Field positions in the operating-system control register.
    localparam int OS_LOCK_BIT = 0;
    localparam int OS_VALID_BIT = 1;

    // Field positions in the main configuration register.
    localparam int MAIN_NO_ARR_BIT = 31;
    localparam int MAIN_FLOAT_BIT = 30;
    localparam int MAIN_ARRAY_PTR_BIT = 29;
    localparam int MAIN_OBJECT_PTR_BIT = 28;
    localparam int MAIN_IS_BIT = 27;
    localparam int MAIN_SP_BIT = 26;
    localparam int MAIN_ENABLE_BIT = 0;

    // Writable bits of the main configuration register; the float bit is absent.
    localparam logic [31:0] MAIN_WMASK = 32'hbc00_0001;

    // Reset values.
    localparam logic [31:0] OS_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] MAIN_CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] PARAMS_RESET = 32'h0000_0000;

    // One coprocessor register transfer from the core.
    typedef struct packed {
        logic        write;
        logic        user_mode;
        logic [2:0]  opc1;
        logic [3:0]  crn;
        logic [3:0]  crm;
        logic [2:0]  opc2;
        logic [31:0] wdata;
    } cp_req_t;

    // Configuration that steers the execution hardware.
    typedef struct packed {
        logic no_array_ops;
        logic array_pointer;
        logic object_pointer;
        logic index_size;
        logic static_pointer;
        logic accel_enable;
    } accel_cfg_t;

endpackage

// *** verilog/cp_access_check.sv ***
// Decode and privilege check for coprocessor transfers to the configuration registers.
`timescale 1ns/100ps
module cp_access_check (
    // Transfer under test.
    input wire accel_cfg_pkg::cp_req_t req_i,
    // Current user-mode lock from the control register.
    input wire logic config_disabled_flag_i,
    // Decode results.
    output logic enc_valid_o,
    output logic trap_o
);

    logic fields_ok;
    logic known_reg;
    logic user_read_trap;
    logic user_write_trap;
    logic user_trap;

    // The transfer must carry the fixed opcodes and name a register that exists.
    assign fields_ok = (req_i.opc1 == accel_cfg_pkg::CP_OPC1) &&
                       (req_i.crm == accel_cfg_pkg::CP_CRM) &&
                       (req_i.opc2 == accel_cfg_pkg::CP_OPC2); // [R11]
    assign known_reg = (req_i.crn <= accel_cfg_pkg::CRN_XLATE);
    assign enc_valid_o = fields_ok && known_reg;

    // User reads pass only for the identification register while unlocked.
    assign user_read_trap = config_disabled_flag_i ||
                            (req_i.crn != accel_cfg_pkg::CRN_IDENT); // [R5] [R6] [R9] [R12]
    // User writes fail for the control register, or for all while locked.
    assign user_write_trap = config_disabled_flag_i ||
                             (req_i.crn == accel_cfg_pkg::CRN_OS_CTRL); // [R7] [R8] [R10] [R18]
    assign user_trap = req_i.write ? user_write_trap : user_read_trap;

    // Privileged transfers trap only on a bad encoding.
    assign trap_o = !enc_valid_o || (req_i.user_mode && user_trap); // [R20]

endmodule

// *** verilog/accel_cfg_regs.sv ***
// Operating-system control and main configuration registers of the bytecode accelerator.
`timescale 1ns/100ps

// Summary of operation
// R1: Entry with invalid configuration raises configuration exception.
// R2: That failed entry sets the valid flag.
// R3: Entry with valid configuration succeeds, no exception.
// R4: Any exception taken clears the valid flag, except when a failed entry sets it in the same cycle.
// R5: Unlocked user read of identification succeeds.
// R6: Unlocked user read of other registers traps.
// R7: Unlocked user write of control register traps.
// R8: Unlocked user writes elsewhere succeed.
// R9: Locked user reads of all registers trap.
// R10: Locked user writes of all registers trap.
// R11: Control register uses opcode 7, c1, c0, 0.
// R12: Main configuration reads need privileged mode.
// R13: Array flag clear allows hardware array operations.
// R14: Array flag set sends arrays to handlers.
// R15: Float flag reads zero, ignores writes.
// R16: Array pointer flag: handles or direct pointers.
// R17: Object pointer flag: handles or direct pointers.
// R18: Control register resets zero, privileged writes only.
// R19: Accelerator disabled makes branch-exchange plain.
// R20: Privileged accesses never trapped by lock flag.
module accel_cfg_regs #(
    // Identification register contents; the value is arbitrary.
    parameter logic [31:0] IDENT_VALUE = 32'h1234_5678
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Coprocessor transfer port from the core.
    input wire logic cp_req_i,
    input wire accel_cfg_pkg::cp_req_t cp_cmd_i,
    output logic cp_done_o,
    output logic cp_undef_o,
    output logic [31:0] cp_rdata_o,
    // Execution events from the core.
    input wire logic accel_entry_i,
    input wire logic exception_taken_i,
    // Entry outcome and identification-write table clear, one-cycle pulses.
    output logic enter_accel_o,
    output logic config_invalid_exc_o,
    output logic plain_branch_exchange_o,
    output logic xlate_clear_o,
    // Configuration levels to the execution hardware.
    output accel_cfg_pkg::accel_cfg_t accel_cfg_o,
    output logic config_valid_flag_o,
    output logic config_disabled_flag_o
);

    // Register state.
    logic config_valid_flag_q;
    logic config_valid_flag_d;
    logic config_disabled_flag_q;
    logic config_disabled_flag_d;
    logic [31:0] main_cfg_q;
    logic [31:0] main_cfg_d;
    logic [31:0] params_q;
    logic [31:0] params_d;

    // Answer and event pulse state.
    logic cp_done_q;
    logic cp_undef_q;
    logic [31:0] cp_rdata_q;
    logic [31:0] cp_rdata_d;
    logic enter_accel_q;
    logic config_invalid_exc_q;
    logic plain_branch_q;
    logic xlate_clear_q;

    // Decode wires.
    logic enc_valid;
    logic trap;
    logic accepted;
    logic wr_os;
    logic wr_main;
    logic wr_params;
    logic wr_ident;
    logic rd_go;
    logic accel_on;
    logic entry_fail;
    logic entry_ok;
    logic entry_plain;
    logic [31:0] os_word;

    // Permission and encoding check.
    cp_access_check u_check (
        .req_i(cp_cmd_i),
        .config_disabled_flag_i(config_disabled_flag_q),
        .enc_valid_o(enc_valid),
        .trap_o(trap)
    );

    // Transfer decode; a trapped transfer changes no state.
    assign accepted = cp_req_i && !trap;
    assign wr_os = accepted && cp_cmd_i.write &&
                   (cp_cmd_i.crn == accel_cfg_pkg::CRN_OS_CTRL); // [R11] [R18]
    assign wr_main = accepted && cp_cmd_i.write &&
                     (cp_cmd_i.crn == accel_cfg_pkg::CRN_MAIN_CFG); // [R8]
    assign wr_params = accepted && cp_cmd_i.write &&
                       (cp_cmd_i.crn == accel_cfg_pkg::CRN_PARAMS);
    assign wr_ident = accepted && cp_cmd_i.write &&
                      (cp_cmd_i.crn == accel_cfg_pkg::CRN_IDENT);
    assign rd_go = accepted && !cp_cmd_i.write;

    // Entry attempt outcome.
    assign accel_on = main_cfg_q[accel_cfg_pkg::MAIN_ENABLE_BIT];
    assign entry_plain = accel_entry_i && !accel_on; // [R19]
    assign entry_fail = accel_entry_i && accel_on && !config_valid_flag_q; // [R1]
    assign entry_ok = accel_entry_i && accel_on && config_valid_flag_q; // [R3]

    // Valid flag: a failed entry sets it and wins over any clear in the same cycle.
    assign config_valid_flag_d = entry_fail ? 1'b1 : // [R2]
                                 exception_taken_i ? 1'b0 : // [R4]
                                 wr_os ? cp_cmd_i.wdata[accel_cfg_pkg::OS_VALID_BIT] :
                                 config_valid_flag_q;
    assign config_disabled_flag_d = wr_os ? cp_cmd_i.wdata[accel_cfg_pkg::OS_LOCK_BIT] :
                                    config_disabled_flag_q;

    // Main configuration keeps the float bit at zero through the write mask.
    assign main_cfg_d = wr_main ? (cp_cmd_i.wdata & accel_cfg_pkg::MAIN_WMASK) :
                        main_cfg_q; // [R15]
    assign params_d = wr_params ? cp_cmd_i.wdata : params_q;

    // Read data; reserved control bits and the write-only table read as zero.
    assign os_word = {30'h0000_0000, config_valid_flag_q, config_disabled_flag_q};
    assign cp_rdata_d = !rd_go ? 32'h0000_0000 :
                        (cp_cmd_i.crn == accel_cfg_pkg::CRN_IDENT) ? IDENT_VALUE :
                        (cp_cmd_i.crn == accel_cfg_pkg::CRN_OS_CTRL) ? os_word :
                        (cp_cmd_i.crn == accel_cfg_pkg::CRN_MAIN_CFG) ? main_cfg_q :
                        (cp_cmd_i.crn == accel_cfg_pkg::CRN_PARAMS) ? params_q :
                        32'h0000_0000;

    // Configuration registers.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            config_valid_flag_q <=
                accel_cfg_pkg::OS_CTRL_RESET[accel_cfg_pkg::OS_VALID_BIT]; // [R18]
            config_disabled_flag_q <= accel_cfg_pkg::OS_CTRL_RESET[accel_cfg_pkg::OS_LOCK_BIT];
            main_cfg_q <= accel_cfg_pkg::MAIN_CFG_RESET;
            params_q <= accel_cfg_pkg::PARAMS_RESET;
        end else begin
            config_valid_flag_q <= config_valid_flag_d;
            config_disabled_flag_q <= config_disabled_flag_d;
            main_cfg_q <= main_cfg_d;
            params_q <= params_d;
        end
    end

    // Transfer answer, one cycle after the request.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cp_done_q <= 1'b0;
            cp_undef_q <= 1'b0;
            cp_rdata_q <= 32'h0000_0000;
            xlate_clear_q <= 1'b0;
        end else begin
            cp_done_q <= cp_req_i;
            cp_undef_q <= cp_req_i && trap; // [R6] [R7] [R9] [R10]
            cp_rdata_q <= cp_rdata_d;
            xlate_clear_q <= wr_ident;
        end
    end

    // Entry outcome pulses.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            enter_accel_q <= 1'b0;
            config_invalid_exc_q <= 1'b0;
            plain_branch_q <= 1'b0;
        end else begin
            enter_accel_q <= entry_ok; // [R3]
            config_invalid_exc_q <= entry_fail; // [R1]
            plain_branch_q <= entry_plain; // [R19]
        end
    end

    // Outputs, all taken from flip-flops.
    assign cp_done_o = cp_done_q;
    assign cp_undef_o = cp_undef_q;
    assign cp_rdata_o = cp_rdata_q;
    assign enter_accel_o = enter_accel_q;
    assign config_invalid_exc_o = config_invalid_exc_q;
    assign plain_branch_exchange_o = plain_branch_q;
    assign xlate_clear_o = xlate_clear_q;
    assign config_valid_flag_o = config_valid_flag_q;
    assign config_disabled_flag_o = config_disabled_flag_q;

    // Array handling and reference formats steer the execution hardware.
    assign accel_cfg_o.no_array_ops = main_cfg_q[accel_cfg_pkg::MAIN_NO_ARR_BIT]; // [R13] [R14]
    assign accel_cfg_o.array_pointer = main_cfg_q[accel_cfg_pkg::MAIN_ARRAY_PTR_BIT]; // [R16]
    assign accel_cfg_o.object_pointer = main_cfg_q[accel_cfg_pkg::MAIN_OBJECT_PTR_BIT]; // [R17]
    assign accel_cfg_o.index_size = main_cfg_q[accel_cfg_pkg::MAIN_IS_BIT];
    assign accel_cfg_o.static_pointer = main_cfg_q[accel_cfg_pkg::MAIN_SP_BIT];
    assign accel_cfg_o.accel_enable = main_cfg_q[accel_cfg_pkg::MAIN_ENABLE_BIT];

    // Checks on entry handling.
    a_entry_fail_exc: assert property ( // [R1]
        @(posedge clk_i) disable iff (!reset_n_i)
        (accel_entry_i && accel_on && !config_valid_flag_q)
        |=> (config_invalid_exc_o && !enter_accel_o))
        else $error("Invalid entry did not raise configuration exception.");

    a_entry_sets_valid: assert property ( // [R2]
        @(posedge clk_i) disable iff (!reset_n_i)
        (accel_entry_i && accel_on && !config_valid_flag_q) |=> config_valid_flag_o)
        else $error("Failed entry did not mark configuration valid.");

    a_entry_ok_path: assert property ( // [R3]
        @(posedge clk_i) disable iff (!reset_n_i)
        (accel_entry_i && accel_on && config_valid_flag_q)
        |=> (enter_accel_o && !config_invalid_exc_o))
        else $error("Valid entry did not enter accelerated state.");

    a_exc_clears_valid: assert property ( // [R4]
        @(posedge clk_i) disable iff (!reset_n_i)
        (exception_taken_i && !entry_fail) |=> !config_valid_flag_o)
        else $error("Exception did not clear the valid flag.");

    a_plain_branch_path: assert property ( // [R19]
        @(posedge clk_i) disable iff (!reset_n_i)
        (accel_entry_i && !main_cfg_q[accel_cfg_pkg::MAIN_ENABLE_BIT])
        |=> (plain_branch_exchange_o && !enter_accel_o && !config_invalid_exc_o))
        else $error("Disabled accelerator did not give plain branch-exchange.");

    // Checks on user-mode access control.
    a_user_ident_read: assert property ( // [R5]
        @(posedge clk_i) disable iff (!reset_n_i)
        (cp_req_i && enc_valid && cp_cmd_i.user_mode && !cp_cmd_i.write &&
         !config_disabled_flag_o && cp_cmd_i.crn == accel_cfg_pkg::CRN_IDENT)
        |=> (cp_done_o && !cp_undef_o && cp_rdata_o == IDENT_VALUE))
        else $error("Unlocked user identification read failed.");

    a_user_other_read: assert property ( // [R6]
        @(posedge clk_i) disable iff (!reset_n_i)
        (cp_req_i && cp_cmd_i.user_mode && !cp_cmd_i.write &&
         cp_cmd_i.crn != accel_cfg_pkg::CRN_IDENT)
        |=> (cp_done_o && cp_undef_o && cp_rdata_o == 32'h0000_0000))
        else $error("User read of a privileged register did not trap.");

    a_user_os_write: assert property ( // [R7]
        @(posedge clk_i) disable iff (!reset_n_i)
        (cp_req_i && cp_cmd_i.user_mode && cp_cmd_i.write &&
         cp_cmd_i.crn == accel_cfg_pkg::CRN_OS_CTRL)
        |=> (cp_undef_o && $stable(config_disabled_flag_o)))
        else $error("User write of control register did not trap.");

    a_user_main_write: assert property ( // [R8]
        @(posedge clk_i) disable iff (!reset_n_i)
        (cp_req_i && enc_valid && cp_cmd_i.user_mode && cp_cmd_i.write &&
         !config_disabled_flag_o && cp_cmd_i.crn == accel_cfg_pkg::CRN_MAIN_CFG)
        |=> (!cp_undef_o && accel_cfg_o.accel_enable == $past(cp_cmd_i.wdata[0])))
        else $error("Unlocked user write of main configuration failed.");

    a_user_locked_trap: assert property ( // [R9] [R10]
        @(posedge clk_i) disable iff (!reset_n_i)
        (cp_req_i && cp_cmd_i.user_mode && config_disabled_flag_o)
        |=> (cp_done_o && cp_undef_o))
        else $error("Locked user access did not trap.");

    a_priv_no_trap: assert property ( // [R20]
        @(posedge clk_i) disable iff (!reset_n_i)
        (cp_req_i && enc_valid && !cp_cmd_i.user_mode) |=> (cp_done_o && !cp_undef_o))
        else $error("Privileged access was trapped.");

    // A read of the main configuration never shows the float flag.
    a_float_reads_zero: assert property ( // [R15]
        @(posedge clk_i) disable iff (!reset_n_i)
        (cp_req_i && enc_valid && !cp_cmd_i.user_mode && !cp_cmd_i.write &&
         cp_cmd_i.crn == accel_cfg_pkg::CRN_MAIN_CFG)
        |=> !cp_rdata_o[accel_cfg_pkg::MAIN_FLOAT_BIT])
        else $error("Float opcode flag read back as set.");

    // Checks on encoding, privileged writes and the table clear pulse.
    a_bad_enc_trap: assert property ( // [R11]
        @(posedge clk_i) disable iff (!reset_n_i)
        (cp_req_i && (cp_cmd_i.opc1 != accel_cfg_pkg::CP_OPC1 ||
         cp_cmd_i.crn > accel_cfg_pkg::CRN_XLATE))
        |=> (cp_done_o && cp_undef_o && cp_rdata_o == 32'h0000_0000))
        else $error("Transfer with a bad encoding was not trapped.");

    a_priv_os_write: assert property ( // [R18]
        @(posedge clk_i) disable iff (!reset_n_i)
        (cp_req_i && enc_valid && !cp_cmd_i.user_mode && cp_cmd_i.write &&
         cp_cmd_i.crn == accel_cfg_pkg::CRN_OS_CTRL)
        |=> (config_disabled_flag_o == $past(cp_cmd_i.wdata[accel_cfg_pkg::OS_LOCK_BIT])))
        else $error("Privileged control write did not land.");

    a_ident_write_clear: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (cp_req_i && enc_valid && !cp_cmd_i.user_mode && cp_cmd_i.write &&
         cp_cmd_i.crn == accel_cfg_pkg::CRN_IDENT)
        |=> xlate_clear_o)
        else $error("Identification write did not clear the table.");

endmodule

// *** test/core_model.sv ***
// Core-side model that issues coprocessor transfers and execution events.
`timescale 1ns/100ps
module core_model (
    // Clock and answer from the registers.
    input wire logic clk_i,
    input wire logic cp_done_i,
    input wire logic cp_undef_i,
    input wire logic [31:0] cp_rdata_i,
    // Requests and execution events to the registers.
    output logic cp_req_o,
    output accel_cfg_pkg::cp_req_t cp_cmd_o,
    output logic accel_entry_o,
    output logic exception_taken_o
);
    // Idle outputs from time zero.
    initial begin
        cp_req_o = 1'h0;
        cp_cmd_o = '0;
        accel_entry_o = 1'h0;
        exception_taken_o = 1'h0;
    end

    // One transfer: the request stands for one edge and the answer is taken one edge later.
    task automatic xfer(input logic wr, input logic usr, input logic [2:0] op1,
            input logic [3:0] crn, input logic [31:0] wd, output logic done,
            output logic undef, output logic [31:0] rd);
        @(posedge clk_i);
        cp_req_o <= 1'h1;
        cp_cmd_o <= '{wr, usr, op1, crn, accel_cfg_pkg::CP_CRM, accel_cfg_pkg::CP_OPC2, wd};
        @(posedge clk_i);
        cp_req_o <= 1'h0;
        cp_cmd_o <= ~cp_cmd_o; // Stale command is scrambled so it cannot be reused silently.
        @(posedge clk_i);
        done = cp_done_i;
        undef = cp_undef_i;
        rd = cp_rdata_i;
    endtask

    // An entry attempt or an exception, each a pulse of one cycle.
    task automatic event_pulse(input logic ent, input logic exc);
        @(posedge clk_i);
        accel_entry_o <= ent;
        exception_taken_o <= exc;
        @(posedge clk_i);
        accel_entry_o <= 1'h0;
        exception_taken_o <= 1'h0;
    endtask
endmodule

// *** test/test_accel_cfg_regs.sv ***
// Self-checking testbench of the accelerator configuration registers.
`timescale 1ns/100ps
module test_accel_cfg_regs;
    localparam logic [31:0] IDENT = 32'h0bad_cafe; // Arbitrary identification value.
    localparam logic [2:0] OP1 = accel_cfg_pkg::CP_OPC1;
    logic clk_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic cp_req, cp_done, cp_undef, entry, exc, enter_o, inval_o, plain_o, cv, cd, xlate;
    logic [31:0] cp_rdata;
    accel_cfg_pkg::cp_req_t cp_cmd;
    accel_cfg_pkg::accel_cfg_t cfg;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    int i;

    accel_cfg_regs #(.IDENT_VALUE(IDENT)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .cp_req_i(cp_req), .cp_cmd_i(cp_cmd), .cp_done_o(cp_done), .cp_undef_o(cp_undef),
        .cp_rdata_o(cp_rdata), .accel_entry_i(entry), .exception_taken_i(exc),
        .enter_accel_o(enter_o), .config_invalid_exc_o(inval_o),
        .plain_branch_exchange_o(plain_o), .xlate_clear_o(xlate), .accel_cfg_o(cfg),
        .config_valid_flag_o(cv), .config_disabled_flag_o(cd));

    core_model i_core (.clk_i(clk_i), .cp_done_i(cp_done), .cp_undef_i(cp_undef),
        .cp_rdata_i(cp_rdata), .cp_req_o(cp_req), .cp_cmd_o(cp_cmd),
        .accel_entry_o(entry), .exception_taken_o(exc));

    // Clock of 25 ns period.
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
        end
    endtask

    // One transfer checked for its answer, trap and read data.
    task automatic xf(input logic wr, input logic usr, input logic [2:0] op1,
            input logic [3:0] crn, input logic [31:0] wd, input logic ex_undef,
            input logic [31:0] ex_rd);
        logic done, undef;
        logic [31:0] rd;
        i_core.xfer(wr, usr, op1, crn, wd, done, undef, rd);
        chk1(done, 1'h1, "transfer answer");
        chk1(undef, ex_undef, "trap");
        chk32(rd, ex_rd, "read data");
        // Only an accepted identification write clears the translation table.
        chk1(xlate, wr && !ex_undef && crn == accel_cfg_pkg::CRN_IDENT, "table clear");
    endtask

    // Entry or exception event, then the outcome pulses and valid flag one cycle on.
    task automatic ev(input logic ent, input logic ex, input logic [2:0] ex_p, input logic ex_cv);
        i_core.event_pulse(ent, ex);
        @(posedge clk_i);
        chk32({29'h0, enter_o, inval_o, plain_o}, {29'h0, ex_p}, "entry outcome");
        chk1(cv, ex_cv, "valid flag");
    endtask

    // Cuts a hang short.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            end_sim();
        end
    end

    // Main sequence of transfers and events.
    initial begin
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'h1;
        chk32({26'h0, cfg}, 32'h0, "configuration after reset");
        xf(1'h0, 1'h0, OP1, accel_cfg_pkg::CRN_OS_CTRL, 32'h0, 1'h0, 32'h0);
        ev(1'h1, 1'h0, 3'h1, 1'h0);
        xf(1'h1, 1'h0, OP1, accel_cfg_pkg::CRN_MAIN_CFG, 32'hffff_ffff, 1'h0, 32'h0);
        xf(1'h0, 1'h0, OP1, accel_cfg_pkg::CRN_MAIN_CFG, 32'h0, 1'h0, 32'hbc00_0001);
        chk1(cfg.no_array_ops, 1'h1, "array flag set");
        chk1(cfg.array_pointer, 1'h1, "array pointer set");
        chk1(cfg.object_pointer, 1'h1, "object pointer set");
        ev(1'h1, 1'h0, 3'h2, 1'h1);
        ev(1'h1, 1'h0, 3'h4, 1'h1);
        ev(1'h0, 1'h1, 3'h0, 1'h0);
        // Failed entry and exception together: the set wins.
        ev(1'h1, 1'h1, 3'h2, 1'h1);
        ev(1'h0, 1'h1, 3'h0, 1'h0);
        xf(1'h1, 1'h0, OP1, accel_cfg_pkg::CRN_MAIN_CFG, 32'h0000_0001, 1'h0, 32'h0);
        chk32({26'h0, cfg}, 32'h1, "flags cleared");
        // User mode while unlocked.
        xf(1'h0, 1'h1, OP1, accel_cfg_pkg::CRN_IDENT, 32'h0, 1'h0, IDENT);
        for (i = 1; i < 5; i++) begin
            xf(1'h0, 1'h1, OP1, i[3:0], 32'h0, 1'h1, 32'h0);
        end
        xf(1'h1, 1'h1, OP1, accel_cfg_pkg::CRN_OS_CTRL, 32'h3, 1'h1, 32'h0);
        chk32({30'h0, cv, cd}, 32'h0, "control after trapped write");
        xf(1'h1, 1'h1, OP1, accel_cfg_pkg::CRN_PARAMS, 32'h55, 1'h0, 32'h0);
        xf(1'h1, 1'h1, OP1, accel_cfg_pkg::CRN_MAIN_CFG, 32'h2000_0001, 1'h0, 32'h0);
        xf(1'h0, 1'h0, OP1, accel_cfg_pkg::CRN_PARAMS, 32'h0, 1'h0, 32'h55);
        chk1(cfg.array_pointer, 1'h1, "user write landed");
        // Lock user mode, then every user access traps.
        xf(1'h1, 1'h0, OP1, accel_cfg_pkg::CRN_OS_CTRL, 32'h1, 1'h0, 32'h0);
        chk1(cd, 1'h1, "lock flag");
        for (i = 0; i < 5; i++) begin
            xf(1'h0, 1'h1, OP1, i[3:0], 32'h0, 1'h1, 32'h0);
            xf(1'h1, 1'h1, OP1, i[3:0], 32'h0, 1'h1, 32'h0);
        end
        xf(1'h0, 1'h0, OP1, accel_cfg_pkg::CRN_MAIN_CFG, 32'h0, 1'h0, 32'h2000_0001);
        xf(1'h0, 1'h0, OP1, accel_cfg_pkg::CRN_OS_CTRL, 32'h0, 1'h0, 32'h1);
        xf(1'h0, 1'h0, 3'h6, accel_cfg_pkg::CRN_OS_CTRL, 32'h0, 1'h1, 32'h0);
        xf(1'h0, 1'h0, OP1, 4'h5, 32'h0, 1'h1, 32'h0);
        xf(1'h1, 1'h0, OP1, accel_cfg_pkg::CRN_IDENT, 32'h0, 1'h0, 32'h0);
        // A second reset in mid-run brings the control register back to zero.
        @(posedge clk_i);
        reset_n_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'h1;
        chk32({26'h0, cfg}, 32'h0, "configuration after second reset");
        chk32({30'h0, cv, cd}, 32'h0, "control after second reset");
        xf(1'h0, 1'h0, OP1, accel_cfg_pkg::CRN_OS_CTRL, 32'h0, 1'h0, 32'h0);
        end_sim();
    end
endmodule
